// ===== rtl/vcc_pkg.sv
// package: register map, field layout and encodings of the comparator block
package vcc_pkg;

  // number of comparator instances
  localparam int unsigned VCC_NUM_CMP = 2;

  // register addresses on the special function register port
  localparam logic [7:0] VCC_CTRL0_ADDR = 8'h9B;
  localparam logic [7:0] VCC_MODE0_ADDR = 8'h9D;
  localparam logic [7:0] VCC_CTRL1_ADDR = 8'h9A;
  localparam logic [7:0] VCC_MODE1_ADDR = 8'h9C;

  // control register field positions
  localparam int unsigned VCC_ON_BIT = 7;
  localparam int unsigned VCC_LEVEL_BIT = 6;
  localparam int unsigned VCC_RISE_BIT = 5;
  localparam int unsigned VCC_FALL_BIT = 4;
  localparam int unsigned VCC_UPH_LSB = 2;
  localparam int unsigned VCC_DNH_LSB = 0;

  // mode register field positions
  localparam int unsigned VCC_MODE_RSV_BIT = 7;
  localparam int unsigned VCC_RIE_BIT = 5;
  localparam int unsigned VCC_FIE_BIT = 4;
  localparam int unsigned VCC_MD_LSB = 0;

  // reset values
  localparam logic [7:0] VCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] VCC_MODE_RESET = 8'h82;
  localparam logic [1:0] VCC_MD_RESET = 2'h2;
  localparam logic [1:0] VCC_HYST_RESET = 2'h0;

  // nominal hysteresis amounts in millivolts per level
  localparam int unsigned VCC_HYST_MV_LVL1 = 5;
  localparam int unsigned VCC_HYST_MV_LVL2 = 10;
  localparam int unsigned VCC_HYST_MV_LVL3 = 20;

  // response time modes, fastest to lowest power
  typedef enum logic [1:0] {
    VCC_RESP_FAST = 2'b00,
    VCC_RESP_MID1 = 2'b01,
    VCC_RESP_MID2 = 2'b10,
    VCC_RESP_SLOW = 2'b11
  } vcc_resp_t;

  // hysteresis levels, shared by the rising and falling side
  typedef enum logic [1:0] {
    VCC_HYST_OFF = 2'b00,
    VCC_HYST_LVL1 = 2'b01,
    VCC_HYST_LVL2 = 2'b10,
    VCC_HYST_LVL3 = 2'b11
  } vcc_hyst_t;

endpackage : vcc_pkg

// ===== rtl/vcc_channel.sv
// one comparator channel: synchroniser, edge detection, sticky flags, irq
`timescale 1ns/1ns
`default_nettype none

module vcc_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raw_i,
  input wire logic enable_i,
  input wire logic flag_wr_i,
  input wire logic rise_wdata_i,
  input wire logic fall_wdata_i,
  input wire logic rise_irq_allow_i,
  input wire logic fall_irq_allow_i,
  input wire logic src_en_i,
  input wire logic global_en_i,
  output logic level_o,
  output logic rise_seen_o,
  output logic fall_seen_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic level_prev;
    logic rise;
    logic fall;
  } vcc_chan_state_t;

  vcc_chan_state_t state_q;
  vcc_chan_state_t state_d;
  logic rise_ev;
  logic fall_ev;

  ////////////////////////////////////////////////////////////////////////////
  // edge events from two consecutive samples of the gated synced level,
  // so a shutdown shows its falling edge in the cycle it happens
  assign rise_ev = level_o & ~state_q.level_prev; // [RULE_25]
  assign fall_ev = ~level_o & state_q.level_prev; // [RULE_25]

  // next state: sync chain, level, and flags where a set beats a clear
  always_comb begin
    state_d = state_q;
    state_d.sync1 = raw_i; // [RULE_03]
    state_d.sync2 = state_q.sync1;
    state_d.level = state_q.sync2 & enable_i; // [RULE_02] [RULE_03]
    state_d.level_prev = level_o;
    if (flag_wr_i) begin
      state_d.rise = rise_wdata_i; // [RULE_19]
      state_d.fall = fall_wdata_i; // [RULE_19]
    end
    // flags set regardless of interrupt enables, never auto cleared
    state_d.rise = state_d.rise | rise_ev; // [RULE_05] [RULE_06] [RULE_07]
    state_d.fall = state_d.fall | fall_ev; // [RULE_05] [RULE_06] [RULE_07]
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; the irq is the gated OR of both flags
  assign level_o = state_q.level & enable_i; // [RULE_02]
  assign rise_seen_o = state_q.rise;
  assign fall_seen_o = state_q.fall;
  assign irq_o = global_en_i & src_en_i & // [RULE_09]
    ((state_q.rise & rise_irq_allow_i) | // [RULE_26] [RULE_08]
     (state_q.fall & fall_irq_allow_i)); // [RULE_26] [RULE_08]

  ////////////////////////////////////////////////////////////////////////////
  // flag stays set unless software writes it
  a_rise_sticky: assert property (@(posedge clk_i) // [RULE_07]
    disable iff (rst_i)
    (state_q.rise && !flag_wr_i) |=> state_q.rise)
    else $error("rise flag dropped without a write");

  // a write racing an edge keeps the flag
  a_set_wins: assert property (@(posedge clk_i) // [RULE_06]
    disable iff (rst_i)
    (fall_ev && flag_wr_i && !fall_wdata_i) |=> state_q.fall)
    else $error("fall event lost under a clear");

endmodule : vcc_channel

`default_nettype wire

// ===== rtl/vcc_top.sv
// comparator control: registers, output gating, two channels and checks
//
// Behaviour
// RULE_01 - enabled output high when plus exceeds minus
// RULE_02 - disabled comparator forces both outputs zero
// RULE_03 - result synchronised; readable, irq source, pin
// RULE_04 - raw output unsynchronised, valid without clock
// RULE_05 - separate rising and falling flags per comparator
// RULE_06 - flags set regardless of interrupt enables
// RULE_07 - flags stay set until software clears
// RULE_08 - separate rising and falling interrupt enables
// RULE_09 - irq needs source enable and global enable
// RULE_10 - four response modes, fastest to lowest power
// RULE_11 - cleared enable puts comparator in shutdown
// RULE_12 - positive hysteresis delays rising output
// RULE_13 - negative hysteresis delays falling output
// RULE_14 - hysteresis levels 0, 5, 10, 20 mV
// RULE_15 - software sets enable before use
// RULE_16 - software clears flags after setting changes
// RULE_17 - control bit 7 is enable, reset zero
// RULE_18 - control bit 6 reads synced result
// RULE_19 - control bits 5, 4 are edge flags
// RULE_20 - control bits 3:2 select positive hysteresis
// RULE_21 - control bits 1:0 select negative hysteresis
// RULE_22 - both comparators share identical logic
// RULE_23 - mode bits 5, 4 enable edge interrupts
// RULE_24 - mode bits 1:0 response mode, reset 10
// RULE_25 - edges from consecutive synced samples
// RULE_26 - irq is OR of enabled flags
`timescale 1ns/1ns
`default_nettype none

module vcc_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // special function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // analog front end
  input wire logic [vcc_pkg::VCC_NUM_CMP-1:0] cmp_result_i,
  output logic [vcc_pkg::VCC_NUM_CMP-1:0] cmp_on_o,
  output logic [vcc_pkg::VCC_NUM_CMP-1:0][1:0] up_hyst_sel_o,
  output logic [vcc_pkg::VCC_NUM_CMP-1:0][1:0] down_hyst_sel_o,
  output vcc_pkg::vcc_resp_t [vcc_pkg::VCC_NUM_CMP-1:0] resp_mode_o,
  // comparator outputs toward port pins and wake-up logic
  output logic [vcc_pkg::VCC_NUM_CMP-1:0] synced_cmp_out_o,
  output logic [vcc_pkg::VCC_NUM_CMP-1:0] raw_cmp_out_o,
  // interrupt handler
  input wire logic [vcc_pkg::VCC_NUM_CMP-1:0] irq_src_en_i,
  input wire logic irq_global_en_i,
  output logic [vcc_pkg::VCC_NUM_CMP-1:0] irq_req_o
);

  import vcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam int unsigned N = VCC_NUM_CMP;

  // address of each channel's registers, index 0 is the first comparator
  localparam logic [N-1:0][7:0] CTRL_ADDR = {VCC_CTRL1_ADDR, VCC_CTRL0_ADDR};
  localparam logic [N-1:0][7:0] MODE_ADDR = {VCC_MODE1_ADDR, VCC_MODE0_ADDR};

  typedef struct packed {
    logic [N-1:0] on;
    logic [N-1:0][1:0] up_hyst;
    logic [N-1:0][1:0] dn_hyst;
    logic [N-1:0] rie;
    logic [N-1:0] fie;
    logic [N-1:0][1:0] md;
    logic [7:0] rdata;
  } vcc_regs_t;

  vcc_regs_t regs_q;
  vcc_regs_t regs_d;

  logic [N-1:0] level;
  logic [N-1:0] rise_flag;
  logic [N-1:0] fall_flag;
  logic [N-1:0] flag_wr;
  logic [N-1:0] raw_gated;
  logic [N-1:0][7:0] ctrl_img;
  logic [N-1:0][7:0] mode_img;

  ////////////////////////////////////////////////////////////////////////////
  // per channel: register images, raw gating and the channel logic
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      // control image; bit 6 mirrors the synced result
      always_comb begin
        ctrl_img[g] = VCC_CTRL_RESET;
        ctrl_img[g][VCC_ON_BIT] = regs_q.on[g]; // [RULE_17]
        ctrl_img[g][VCC_LEVEL_BIT] = synced_cmp_out_o[g]; // [RULE_18]
        ctrl_img[g][VCC_RISE_BIT] = rise_flag[g]; // [RULE_19]
        ctrl_img[g][VCC_FALL_BIT] = fall_flag[g]; // [RULE_19]
        ctrl_img[g][VCC_UPH_LSB +: 2] = regs_q.up_hyst[g]; // [RULE_20]
        ctrl_img[g][VCC_DNH_LSB +: 2] = regs_q.dn_hyst[g]; // [RULE_21]
      end

      // mode image; reserved bit 7 reads one, unused bits zero
      always_comb begin
        mode_img[g] = 8'h00;
        mode_img[g][VCC_MODE_RSV_BIT] = VCC_MODE_RESET[VCC_MODE_RSV_BIT];
        mode_img[g][VCC_RIE_BIT] = regs_q.rie[g]; // [RULE_23]
        mode_img[g][VCC_FIE_BIT] = regs_q.fie[g]; // [RULE_23]
        mode_img[g][VCC_MD_LSB +: 2] = regs_q.md[g]; // [RULE_24]
      end

      // a control write also writes the edge flags
      assign flag_wr[g] = sfr_wr_i && (sfr_addr_i == CTRL_ADDR[g]);

      // raw path has no flop so it works with the clock stopped
      assign raw_gated[g] = cmp_result_i[g] & regs_q.on[g]; // [RULE_02]

      // identical logic for every comparator
      vcc_channel u_chan ( // [RULE_22]
        .clk_i(clk_i),
        .rst_i(rst_i),
        .raw_i(cmp_result_i[g]), // synchronised before any gate
        .enable_i(regs_q.on[g]),
        .flag_wr_i(flag_wr[g]),
        .rise_wdata_i(sfr_wdata_i[VCC_RISE_BIT]),
        .fall_wdata_i(sfr_wdata_i[VCC_FALL_BIT]),
        .rise_irq_allow_i(regs_q.rie[g]),
        .fall_irq_allow_i(regs_q.fie[g]),
        .src_en_i(irq_src_en_i[g]),
        .global_en_i(irq_global_en_i),
        .level_o(level[g]),
        .rise_seen_o(rise_flag[g]),
        .fall_seen_o(fall_flag[g]),
        .irq_o(irq_req_o[g])
      );

      // outputs toward the analog front end and port pins
      assign raw_cmp_out_o[g] = raw_gated[g]; // [RULE_01] [RULE_04]
      assign synced_cmp_out_o[g] = level[g]; // [RULE_03]
      assign cmp_on_o[g] = regs_q.on[g]; // [RULE_11]
      assign up_hyst_sel_o[g] = regs_q.up_hyst[g]; // [RULE_12] [RULE_14]
      assign down_hyst_sel_o[g] = regs_q.dn_hyst[g]; // [RULE_13] [RULE_14]
      assign resp_mode_o[g] = vcc_resp_t'(regs_q.md[g]); // [RULE_10]

      ////////////////////////////////////////////////////////////////////////
      // a rising synced level sets the rising flag next cycle
      a_rise_sets_flag: assert property (@(posedge clk_i) // [RULE_06]
        disable iff (rst_i) $rose(level[g]) |=> rise_flag[g])
        else $error("rising edge did not set the flag");

      // a falling synced level sets the falling flag next cycle
      a_fall_sets_flag: assert property (@(posedge clk_i) // [RULE_05]
        disable iff (rst_i) $fell(level[g]) |=> fall_flag[g])
        else $error("falling edge did not set the flag");

      // falling flag holds without a software write
      a_flag_no_autoclr: assert property (@(posedge clk_i) // [RULE_07]
        disable iff (rst_i)
        (fall_flag[g] && !flag_wr[g]) |=> fall_flag[g])
        else $error("falling flag cleared by hardware");

      // switched off means both outputs low
      a_off_outputs_low: assert property (@(posedge clk_i) // [RULE_02]
        disable iff (rst_i)
        !regs_q.on[g] |-> (!raw_cmp_out_o[g] && !synced_cmp_out_o[g]))
        else $error("disabled comparator drives a one");

      // a steady high result reaches the synced output in three edges
      a_sync_latency: assert property (@(posedge clk_i) // [RULE_03]
        disable iff (rst_i)
        (raw_gated[g] && regs_q.on[g])[*3] ##1 regs_q.on[g]
          |-> synced_cmp_out_o[g])
        else $error("synced output late");

      // an irq needs both gates open
      a_irq_gated: assert property (@(posedge clk_i) // [RULE_09]
        disable iff (rst_i)
        irq_req_o[g] |-> (irq_global_en_i && irq_src_en_i[g]))
        else $error("irq without global or source enable");

      // an enabled set flag with gates open raises the irq
      a_irq_from_flag: assert property (@(posedge clk_i) // [RULE_26]
        disable iff (rst_i)
        (irq_global_en_i && irq_src_en_i[g] &&
         ((rise_flag[g] && regs_q.rie[g]) ||
          (fall_flag[g] && regs_q.fie[g]))) |-> irq_req_o[g])
        else $error("enabled flag gave no irq");

      // control read returns the synced level in bit 6
      a_read_level: assert property (@(posedge clk_i) // [RULE_18]
        disable iff (rst_i)
        (sfr_rd_i && sfr_addr_i == CTRL_ADDR[g]) |=>
          sfr_rdata_o[VCC_LEVEL_BIT] == $past(synced_cmp_out_o[g]))
        else $error("control read lost the level bit");

      // mode write lands in the response mode output
      a_mode_write: assert property (@(posedge clk_i) // [RULE_24]
        disable iff (rst_i)
        (sfr_wr_i && sfr_addr_i == MODE_ADDR[g]) |=>
          resp_mode_o[g] == vcc_resp_t'($past(sfr_wdata_i[1:0])))
        else $error("mode field not written");

      // enable bit follows a control write
      a_enable_write: assert property (@(posedge clk_i) // [RULE_17]
        disable iff (rst_i)
        (sfr_wr_i && sfr_addr_i == CTRL_ADDR[g]) |=>
          cmp_on_o[g] == $past(sfr_wdata_i[VCC_ON_BIT]))
        else $error("enable bit not written");

      // raw output tracks the front end while switched on
      a_raw_follows: assert property (@(posedge clk_i) // [RULE_04]
        disable iff (rst_i)
        regs_q.on[g] |-> (raw_cmp_out_o[g] == cmp_result_i[g]))
        else $error("raw output does not follow the front end");

      // hysteresis fields follow a control write
      a_hyst_write: assert property (@(posedge clk_i) // [RULE_20] [RULE_21]
        disable iff (rst_i)
        (sfr_wr_i && sfr_addr_i == CTRL_ADDR[g]) |=>
          (up_hyst_sel_o[g] == $past(sfr_wdata_i[VCC_UPH_LSB +: 2]) &&
           down_hyst_sel_o[g] == $past(sfr_wdata_i[VCC_DNH_LSB +: 2])))
        else $error("hysteresis fields not written");

      // interrupt enables follow a mode write
      a_irq_en_write: assert property (@(posedge clk_i) // [RULE_23]
        disable iff (rst_i)
        (sfr_wr_i && sfr_addr_i == MODE_ADDR[g]) |=>
          (regs_q.rie[g] == $past(sfr_wdata_i[VCC_RIE_BIT]) &&
           regs_q.fie[g] == $past(sfr_wdata_i[VCC_FIE_BIT])))
        else $error("interrupt enables not written");

      // software may set a flag by writing a one
      a_flag_write_set: assert property (@(posedge clk_i) // [RULE_19]
        disable iff (rst_i)
        (flag_wr[g] && sfr_wdata_i[VCC_RISE_BIT]) |=> rise_flag[g])
        else $error("written rising flag not set");

      // no request without an enabled set flag
      a_irq_needs_flag: assert property (@(posedge clk_i) // [RULE_26]
        disable iff (rst_i)
        irq_req_o[g] |-> ((rise_flag[g] && regs_q.rie[g]) ||
          (fall_flag[g] && regs_q.fie[g])))
        else $error("irq without an enabled flag");

      // control read returns both edge flags
      a_read_flags: assert property (@(posedge clk_i) // [RULE_19]
        disable iff (rst_i)
        (sfr_rd_i && sfr_addr_i == CTRL_ADDR[g]) |=>
          (sfr_rdata_o[VCC_RISE_BIT] == $past(rise_flag[g]) &&
           sfr_rdata_o[VCC_FALL_BIT] == $past(fall_flag[g])))
        else $error("control read lost an edge flag");

      // control read returns both hysteresis fields
      a_read_hyst: assert property (@(posedge clk_i) // [RULE_20] [RULE_21]
        disable iff (rst_i)
        (sfr_rd_i && sfr_addr_i == CTRL_ADDR[g]) |=>
          (sfr_rdata_o[VCC_UPH_LSB +: 2] == $past(regs_q.up_hyst[g]) &&
           sfr_rdata_o[VCC_DNH_LSB +: 2] == $past(regs_q.dn_hyst[g])))
        else $error("control read lost a hysteresis field");

      // mode read returns both interrupt enables
      a_read_irq_en: assert property (@(posedge clk_i) // [RULE_23]
        disable iff (rst_i)
        (sfr_rd_i && sfr_addr_i == MODE_ADDR[g]) |=>
          (sfr_rdata_o[VCC_RIE_BIT] == $past(regs_q.rie[g]) &&
           sfr_rdata_o[VCC_FIE_BIT] == $past(regs_q.fie[g])))
        else $error("mode read lost an interrupt enable");

      // main scenarios
      c_rise_flag: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(rise_flag[g]));
      c_fall_flag: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(fall_flag[g]));
      c_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_req_o[g]));
      c_shutdown: cover property (@(posedge clk_i) disable iff (rst_i)
        $fell(cmp_on_o[g]));
      c_power_up: cover property (@(posedge clk_i) disable iff (rst_i)
        $rose(cmp_on_o[g]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register writes and read data, decoded per channel
  always_comb begin
    regs_d = regs_q;
    for (int i = 0; i < N; i++) begin
      if (sfr_wr_i && sfr_addr_i == CTRL_ADDR[i]) begin
        regs_d.on[i] = sfr_wdata_i[VCC_ON_BIT]; // [RULE_11] [RULE_17]
        regs_d.up_hyst[i] = sfr_wdata_i[VCC_UPH_LSB +: 2]; // [RULE_20]
        regs_d.dn_hyst[i] = sfr_wdata_i[VCC_DNH_LSB +: 2]; // [RULE_21]
      end else if (sfr_wr_i && sfr_addr_i == MODE_ADDR[i]) begin
        regs_d.rie[i] = sfr_wdata_i[VCC_RIE_BIT]; // [RULE_08] [RULE_23]
        regs_d.fie[i] = sfr_wdata_i[VCC_FIE_BIT]; // [RULE_08] [RULE_23]
        regs_d.md[i] = sfr_wdata_i[VCC_MD_LSB +: 2]; // [RULE_10] [RULE_24]
      end
    end
    // a read of any other address returns zero
    if (sfr_rd_i) begin
      regs_d.rdata = 8'h00;
      for (int i = 0; i < N; i++) begin
        if (sfr_addr_i == CTRL_ADDR[i]) begin
          regs_d.rdata = ctrl_img[i];
        end else if (sfr_addr_i == MODE_ADDR[i]) begin
          regs_d.rdata = mode_img[i];
        end
      end
    end
  end

  // register state; mode field resets to the documented middle mode
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      regs_q <= '0;
      for (int i = 0; i < N; i++) begin
        regs_q.md[i] <= VCC_MD_RESET; // [RULE_24]
        regs_q.up_hyst[i] <= VCC_HYST_RESET;
        regs_q.dn_hyst[i] <= VCC_HYST_RESET;
      end
    end else begin
      regs_q <= regs_d;
    end
  end

  assign sfr_rdata_o = regs_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // reserved mode bit always reads one
  a_mode_rsv_one: assert property (@(posedge clk_i) // [RULE_24]
    disable iff (rst_i)
    (sfr_rd_i && sfr_addr_i == VCC_MODE0_ADDR) |=>
      sfr_rdata_o[VCC_MODE_RSV_BIT])
    else $error("reserved mode bit read zero");

  // unmapped reads return zero
  a_unmapped_zero: assert property (@(posedge clk_i) // [RULE_17]
    disable iff (rst_i)
    (sfr_rd_i && sfr_addr_i != VCC_CTRL0_ADDR && sfr_addr_i != VCC_CTRL1_ADDR
     && sfr_addr_i != VCC_MODE0_ADDR && sfr_addr_i != VCC_MODE1_ADDR)
      |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  // reserved bit of the second mode register reads one as well
  a_mode1_rsv_one: assert property (@(posedge clk_i) // [RULE_24]
    disable iff (rst_i)
    (sfr_rd_i && sfr_addr_i == VCC_MODE1_ADDR) |=>
      sfr_rdata_o[VCC_MODE_RSV_BIT])
    else $error("second reserved mode bit read zero");

endmodule : vcc_top

`default_nettype wire

// ===== test/vcc_front_model.sv
// behavioural analog front end of one comparator, with hysteresis
`timescale 1ns/1ns
`default_nettype none

module vcc_front_model
  import vcc_pkg::*;
(
  input wire logic on_i,
  input wire logic [1:0] up_i,
  input wire logic [1:0] dn_i,
  input var int plus_mv_i,
  input var int minus_mv_i,
  output logic result_o
);
  logic st = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // nominal hysteresis amount of a two-bit field
  function automatic int hyst_mv(input logic [1:0] f);
    case (f)
      2'h1: return int'(VCC_HYST_MV_LVL1);
      2'h2: return int'(VCC_HYST_MV_LVL2);
      2'h3: return int'(VCC_HYST_MV_LVL3);
      default: return 0;
    endcase
  endfunction : hyst_mv

  ////////////////////////////////////////////////////////////////////////////
  // decision state: rises past upper band, falls past lower band
  always @* begin
    if (!on_i) begin
      st = 1'b0;
    end else if (!st && plus_mv_i > minus_mv_i + hyst_mv(up_i)) begin
      st = 1'b1;
    end else if (st && plus_mv_i < minus_mv_i - hyst_mv(dn_i)) begin
      st = 1'b0;
    end
  end

  // a powered-down stage gives garbage, here a steady one
  assign result_o = on_i ? st : 1'b1;

endmodule : vcc_front_model

`default_nettype wire

// ===== test/vcc_top_tb_top.sv
// testbench: register access, comparator events and interrupt gating
`timescale 1ns/1ns
`default_nettype none

module vcc_top_tb_top;
  import vcc_pkg::*;
  logic clk_i;
  logic rst_i;
  logic [7:0] sfr_addr_i;
  logic sfr_wr_i;
  logic sfr_rd_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic [1:0] cmp_result_i;
  logic [1:0] cmp_on_o;
  logic [1:0][1:0] up_hyst_sel_o;
  logic [1:0][1:0] down_hyst_sel_o;
  vcc_resp_t [1:0] resp_mode_o;
  logic [1:0] synced_cmp_out_o;
  logic [1:0] raw_cmp_out_o;
  logic [1:0] irq_src_en_i;
  logic irq_global_en_i;
  logic [1:0] irq_req_o;
  int pmv [2];
  int nmv [2];
  int fail_count;
  int total_checks;
  logic [7:0] v;

  vcc_top dut (.clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .cmp_result_i, .cmp_on_o, .up_hyst_sel_o,
    .down_hyst_sel_o, .resp_mode_o, .synced_cmp_out_o, .raw_cmp_out_o,
    .irq_src_en_i, .irq_global_en_i, .irq_req_o);

  for (genvar g = 0; g < 2; g++) begin : g_fe
    vcc_front_model fe (.on_i(cmp_on_o[g]), .up_i(up_hyst_sel_o[g]),
      .dn_i(down_hyst_sel_o[g]), .plus_mv_i(pmv[g]),
      .minus_mv_i(nmv[g]), .result_o(cmp_result_i[g]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock only; reset and time-zero inputs are set in the main sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared access and compare tasks
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge clk_i);
    sfr_rd_i <= 1'b0;
    #1;
    d = sfr_rdata_o;
  endtask : rd

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic setv(input int n, input int p, input int m);
    @(posedge clk_i);
    pmv[n] <= p;
    nmv[n] <= m;
    #1;
  endtask : setv

  task automatic irqset(input int n, input logic s, input logic g);
    @(posedge clk_i);
    irq_src_en_i[n] <= s;
    irq_global_en_i <= g;
    #1;
  endtask : irqset

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  // full pass over one comparator channel
  task automatic chan(input int n);
    logic [7:0] ca;
    logic [7:0] ma;
    logic [7:0] r;
    logic [1:0] k2;
    ca = n ? VCC_CTRL1_ADDR : VCC_CTRL0_ADDR;
    ma = n ? VCC_MODE1_ADDR : VCC_MODE0_ADDR;
    rd(ca, r);
    chk("ctrl reset", r, VCC_CTRL_RESET);
    rd(ma, r);
    chk("mode reset", r, VCC_MODE_RESET);
    chk("mode out", {6'h00, resp_mode_o[n]}, 8'h02);
    for (int k = 0; k < 4; k++) begin
      k2 = k[1:0];
      wr(ca, {4'h4, k2, ~k2});
      rd(ca, r);
      chk("ctrl rw", r, {4'h0, k2, ~k2});
      chk("up hyst", {6'h00, up_hyst_sel_o[n]}, {6'h00, k2});
      chk("dn hyst", {6'h00, down_hyst_sel_o[n]}, {6'h00, ~k2});
      wr(ma, {2'h0, k2, 2'h3, k2});
      rd(ma, r);
      chk("mode rw", r, {2'h2, k2, 2'h0, k2});
      chk("resp mode", {6'h00, resp_mode_o[n]}, {6'h00, k2});
    end
    setv(n, 100, 0);
    chk("raw off", {7'h00, raw_cmp_out_o[n]}, 8'h00);
    chk("sync off", {7'h00, synced_cmp_out_o[n]}, 8'h00);
    wr(ca, 8'h80);
    chk("powered", {7'h00, cmp_on_o[n]}, 8'h01);
    chk("raw on", {7'h00, raw_cmp_out_o[n]}, 8'h01);
    cyc(5);
    chk("sync on", {7'h00, synced_cmp_out_o[n]}, 8'h01);
    rd(ca, r);
    chk("rise flag", r, 8'hE0);
    chk("irq masked", {7'h00, irq_req_o[n]}, 8'h00);
    wr(ca, 8'h80);
    rd(ca, r);
    chk("flag clear", r, 8'hC0);
    setv(n, 0, 100);
    chk("raw low", {7'h00, raw_cmp_out_o[n]}, 8'h00);
    cyc(25);
    rd(ca, r);
    chk("fall sticky", r, 8'h90);
    irqset(n, 1'b1, 1'b1);
    wr(ma, 8'hA2);
    chk("irq rise only", {7'h00, irq_req_o[n]}, 8'h00);
    wr(ma, 8'h92);
    chk("irq fall", {7'h00, irq_req_o[n]}, 8'h01);
    irqset(n, 1'b1, 1'b0);
    chk("irq no global", {7'h00, irq_req_o[n]}, 8'h00);
    irqset(n, 1'b0, 1'b1);
    chk("irq no source", {7'h00, irq_req_o[n]}, 8'h00);
    irqset(n, 1'b0, 1'b0);
    wr(ca, 8'h8D);
    setv(n, 115, 100);
    chk("up band hold", {7'h00, raw_cmp_out_o[n]}, 8'h00);
    setv(n, 125, 100);
    chk("up band pass", {7'h00, raw_cmp_out_o[n]}, 8'h01);
    setv(n, 97, 100);
    chk("dn band hold", {7'h00, raw_cmp_out_o[n]}, 8'h01);
    setv(n, 93, 100);
    chk("dn band pass", {7'h00, raw_cmp_out_o[n]}, 8'h00);
    setv(n, 200, 100);
    cyc(5);
    wr(ca, 8'h0D);
    chk("raw shut", {7'h00, raw_cmp_out_o[n]}, 8'h00);
    chk("sync shut", {7'h00, synced_cmp_out_o[n]}, 8'h00);
    wr(ca, 8'h00);
    wr(ma, 8'h82);
    $display("test channel %0d done", n);
  endtask : chan

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_i = 1'b1;
    sfr_addr_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    sfr_wdata_i = 8'h00;
    irq_src_en_i = 2'b00;
    irq_global_en_i = 1'b0;
    pmv = '{0, 0};
    nmv = '{0, 0};
    fail_count = 0;
    total_checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h9E, v);
    chk("unmapped", v, 8'h00);
    $display("test unmapped done");
    chan(0);
    chan(1);
    close_out();
  end

  // watchdog well beyond the expected run of about 220 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    close_out();
  end

endmodule : vcc_top_tb_top

`default_nettype wire
